// [design/tsm_pkg.sv]
package tsm_pkg;

  // Array geometry and timer width
  localparam int TSM_ADDR_W = 13;
  localparam int TSM_DATA_W = 8;
  localparam int TSM_WORDS  = 8192;
  localparam int TSM_TMR_W  = 8;

  // Pin reset values
  localparam logic [TSM_ADDR_W-1:0] TSM_ADDR_RST = 13'h0000;
  localparam logic [TSM_DATA_W-1:0] TSM_DATA_RST = 8'h00;

  // Timing in ns, clear duty in percent
  localparam int TSM_CLK_PERIOD_NS = 5;
  localparam int TSM_T_ACC_NS      = 20;
  localparam int TSM_T_CMP_NS      = 20;
  localparam int TSM_T_WP_NS       = 15;
  localparam int TSM_T_CLR_NS      = 60;
  localparam int TSM_T_WERS_NS     = 5;
  localparam int TSM_T_RSRC_NS     = 30;
  localparam int TSM_T_OHZ_NS      = 8;
  localparam int TSM_CLR_DUTY_PCT  = 10;

  // Least times, rounded up to whole cycles
  localparam int TSM_ACC_INT  = (TSM_T_ACC_NS + TSM_CLK_PERIOD_NS - 1) / TSM_CLK_PERIOD_NS;
  localparam int TSM_CMP_INT  = (TSM_T_CMP_NS + TSM_CLK_PERIOD_NS - 1) / TSM_CLK_PERIOD_NS;
  localparam int TSM_WP_INT   = (TSM_T_WP_NS + TSM_CLK_PERIOD_NS - 1) / TSM_CLK_PERIOD_NS;
  localparam int TSM_CLR_INT  = (TSM_T_CLR_NS + TSM_CLK_PERIOD_NS - 1) / TSM_CLK_PERIOD_NS;
  localparam int TSM_WERS_INT = (TSM_T_WERS_NS + TSM_CLK_PERIOD_NS - 1) / TSM_CLK_PERIOD_NS;
  localparam int TSM_RSRC_INT = (TSM_T_RSRC_NS + TSM_CLK_PERIOD_NS - 1) / TSM_CLK_PERIOD_NS;
  localparam int TSM_OHZ_INT  = (TSM_T_OHZ_NS + TSM_CLK_PERIOD_NS - 1) / TSM_CLK_PERIOD_NS;
  localparam int TSM_GAP_INT  = TSM_CLR_INT * 100 / TSM_CLR_DUTY_PCT;

  localparam logic [TSM_TMR_W-1:0] TSM_ACC_CYC  = TSM_TMR_W'(TSM_ACC_INT);
  localparam logic [TSM_TMR_W-1:0] TSM_CMP_CYC  = TSM_TMR_W'(TSM_CMP_INT);
  localparam logic [TSM_TMR_W-1:0] TSM_WP_CYC   = TSM_TMR_W'(TSM_WP_INT);
  localparam logic [TSM_TMR_W-1:0] TSM_CLR_CYC  = TSM_TMR_W'(TSM_CLR_INT);
  localparam logic [TSM_TMR_W-1:0] TSM_RSRC_CYC = TSM_TMR_W'(TSM_RSRC_INT);
  localparam logic [TSM_TMR_W-1:0] TSM_OHZ_CYC  = TSM_TMR_W'(TSM_OHZ_INT);
  localparam logic [TSM_TMR_W-1:0] TSM_GAP_CYC  = TSM_TMR_W'(TSM_GAP_INT);
  localparam logic [TSM_TMR_W-1:0] TSM_ONE      = 8'h01;

  typedef enum logic [1:0] {
    TSM_OP_READ  = 2'b00,
    TSM_OP_WRITE = 2'b01,
    TSM_OP_CMP   = 2'b10,
    TSM_OP_CLEAR = 2'b11
  } tsm_op_t;

  typedef enum logic [2:0] {
    TSM_ST_IDLE    = 3'b000,
    TSM_ST_SETUP   = 3'b001,
    TSM_ST_ACCESS  = 3'b010,
    TSM_ST_RECOVER = 3'b011,
    TSM_ST_CLEAR   = 3'b100,
    TSM_ST_CLR_REC = 3'b101
  } tsm_state_t;

  typedef struct packed {
    tsm_op_t               op;
    logic [TSM_ADDR_W-1:0] addr;
    logic [TSM_DATA_W-1:0] data;
  } tsm_cmd_t;

  typedef struct packed {
    tsm_op_t               op;
    logic [TSM_DATA_W-1:0] rdata;
    logic                  hit;
  } tsm_resp_t;

endpackage

// [design/tsm_tag_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module tsm_tag_ctrl
  import tsm_pkg::*;
#(
  parameter int ADDR_W = TSM_ADDR_W,
  parameter int DATA_W = TSM_DATA_W
) (
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  // Command port
  input  wire logic              cmd_valid_in,
  input  wire tsm_cmd_t          cmd_in,
  output logic                   cmd_ready_out,
  // Response port
  output logic                   resp_valid_out,
  output var tsm_resp_t          resp_out,
  // Memory pins
  output logic [ADDR_W-1:0]      addr_out,
  output logic [DATA_W-1:0]      data_out,
  output logic                   data_oe_n_out,
  input  wire logic [DATA_W-1:0] data_in,
  output logic                   cs_n_out,
  output logic                   we_n_out,
  output logic                   oe_n_out,
  output logic                   clear_n_out,
  input  wire logic              match_in
);

  if (ADDR_W != TSM_ADDR_W || DATA_W != TSM_DATA_W) begin : g_chk
    $error("tsm_tag_ctrl widths must match the array geometry");
  end

  tsm_state_t               state;
  tsm_state_t               next_state;
  tsm_op_t                  op;
  tsm_op_t                  next_op;
  logic [ADDR_W-1:0]        addr;
  logic [ADDR_W-1:0]        next_addr;
  logic [DATA_W-1:0]        wdata;
  logic [DATA_W-1:0]        next_wdata;
  logic                     cs_n;
  logic                     next_cs_n;
  logic                     we_n;
  logic                     next_we_n;
  logic                     oe_n;
  logic                     next_oe_n;
  logic                     clr_n;
  logic                     next_clr_n;
  logic                     dbus_oe_n;
  logic                     next_dbus_oe_n;
  tsm_resp_t                resp;
  tsm_resp_t                next_resp;
  logic                     resp_valid;
  logic                     next_resp_valid;
  logic                     tmr_load;
  logic [TSM_TMR_W-1:0]     tmr_val;
  logic                     tmr_done;
  logic                     gap_load;
  logic                     gap_done;
  logic                     accept;

  tsm_timer #(.W(TSM_TMR_W)) u_phase_tmr (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .load_in     (tmr_load),
    .load_val_in (tmr_val),
    .done_out    (tmr_done)
  );

  // Spaces clear pulses to bound the clear duty cycle
  tsm_timer #(.W(TSM_TMR_W)) u_gap_tmr (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .load_in     (gap_load),
    .load_val_in (TSM_GAP_CYC - TSM_ONE),
    .done_out    (gap_done)
  );

  assign cmd_ready_out = (state == TSM_ST_IDLE) && !(cmd_in.op == TSM_OP_CLEAR && !gap_done);
  assign accept        = cmd_valid_in && cmd_ready_out;

  always_comb begin
    next_state      = state;
    next_op         = op;
    next_addr       = addr;
    next_wdata      = wdata;
    next_resp       = resp;
    next_resp_valid = 1'b0;
    tmr_load        = 1'b0;
    tmr_val         = '0;
    gap_load        = 1'b0;
    case (state)
      TSM_ST_IDLE: begin
        if (accept) begin
          next_op    = cmd_in.op;
          next_wdata = cmd_in.data;
          if (cmd_in.op == TSM_OP_CLEAR) begin
            next_state = TSM_ST_CLEAR;
            tmr_load   = 1'b1;
            tmr_val    = TSM_CLR_CYC - TSM_ONE;
            gap_load   = 1'b1;
          end else begin
            // Address moves here, where all strobes are high
            next_addr  = cmd_in.addr;
            next_state = TSM_ST_SETUP;
          end
        end
      end
      TSM_ST_SETUP: begin
        next_state = TSM_ST_ACCESS;
        tmr_load   = 1'b1;
        case (op)
          TSM_OP_WRITE: tmr_val = TSM_WP_CYC - TSM_ONE;
          TSM_OP_READ:  tmr_val = TSM_ACC_CYC - TSM_ONE;
          default:      tmr_val = TSM_CMP_CYC - TSM_ONE;
        endcase
      end
      TSM_ST_ACCESS: begin
        if (tmr_done) begin
          next_state       = TSM_ST_RECOVER;
          next_resp.op     = op;
          next_resp.rdata  = (op == TSM_OP_READ) ? data_in : TSM_DATA_RST;
          next_resp.hit    = (op == TSM_OP_CMP) && match_in;
          next_resp_valid  = 1'b1;
          tmr_load         = 1'b1;
          // After a read the device needs time to release the bus
          tmr_val          = (op == TSM_OP_READ) ? (TSM_OHZ_CYC - TSM_ONE) : '0;
        end
      end
      TSM_ST_RECOVER: begin
        if (tmr_done) begin
          next_state = TSM_ST_IDLE;
        end
      end
      TSM_ST_CLEAR: begin
        if (tmr_done) begin
          next_state = TSM_ST_CLR_REC;
          tmr_load   = 1'b1;
          tmr_val    = TSM_RSRC_CYC - TSM_ONE;
        end
      end
      TSM_ST_CLR_REC: begin
        if (tmr_done) begin
          next_state      = TSM_ST_IDLE;
          next_resp.op    = TSM_OP_CLEAR;
          next_resp.rdata = TSM_DATA_RST;
          next_resp.hit   = 1'b0;
          next_resp_valid = 1'b1;
        end
      end
      default: begin
        next_state = TSM_ST_IDLE;
      end
    endcase
    // Pins follow the next state so they change together with it
    next_cs_n      = !(next_state == TSM_ST_ACCESS);
    next_we_n      = !(next_state == TSM_ST_ACCESS && next_op == TSM_OP_WRITE);
    next_oe_n      = !(next_state == TSM_ST_ACCESS && next_op == TSM_OP_READ);
    next_clr_n     = !(next_state == TSM_ST_CLEAR);
    next_dbus_oe_n = (next_op == TSM_OP_READ) && (next_state == TSM_ST_SETUP ||
                     next_state == TSM_ST_ACCESS || next_state == TSM_ST_RECOVER);
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state      <= TSM_ST_IDLE;
      op         <= TSM_OP_READ;
      addr       <= TSM_ADDR_RST;
      wdata      <= TSM_DATA_RST;
      cs_n       <= 1'b1;
      we_n       <= 1'b1;
      oe_n       <= 1'b1;
      clr_n      <= 1'b1;
      dbus_oe_n  <= 1'b0;
      resp       <= '0;
      resp_valid <= 1'b0;
    end else begin
      state      <= next_state;
      op         <= next_op;
      addr       <= next_addr;
      wdata      <= next_wdata;
      cs_n       <= next_cs_n;
      we_n       <= next_we_n;
      oe_n       <= next_oe_n;
      clr_n      <= next_clr_n;
      dbus_oe_n  <= next_dbus_oe_n;
      resp       <= next_resp;
      resp_valid <= next_resp_valid;
    end
  end

  assign addr_out       = addr;
  assign data_out       = wdata;
  assign data_oe_n_out  = dbus_oe_n;
  assign cs_n_out       = cs_n;
  assign we_n_out       = we_n;
  assign oe_n_out       = oe_n;
  assign clear_n_out    = clr_n;
  assign resp_out       = resp;
  assign resp_valid_out = resp_valid;

  // Cycles since the last clear fall, only for the duty check
  logic [TSM_TMR_W-1:0] since_clr;
  logic [TSM_TMR_W-1:0] next_since_clr;
  logic                 clr_n_d;

  always_comb begin
    next_since_clr = since_clr;
    if (clr_n_d && !clr_n) begin
      next_since_clr = TSM_ONE;
    end else if (since_clr != 8'hff) begin
      next_since_clr = since_clr + TSM_ONE;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      since_clr <= 8'hff;
      clr_n_d   <= 1'b1;
    end else begin
      since_clr <= next_since_clr;
      clr_n_d   <= clr_n;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  chk_addr_strobes: assert property ($changed(addr_out) |-> cs_n_out && we_n_out)
    else $error("address changed while a strobe was low");
  chk_clear_width: assert property ($fell(clear_n_out) |-> (!clear_n_out) [*8] ##1 (!clear_n_out) [*4])
    else $error("clear pulse shorter than 12 cycles");
  chk_clear_duty: assert property ((clr_n_d && !clr_n) |-> since_clr >= TSM_GAP_CYC)
    else $error("clear pulses too close together");
  chk_we_before_release: assert property ($rose(clear_n_out) |-> $past(we_n_out) && $past(we_n_out, 2))
    else $error("write enable low near clear release");
  chk_clear_recovery: assert property ($rose(clear_n_out) |-> we_n_out [*6])
    else $error("write enable low too soon after clear");
  chk_write_pulse: assert property ($fell(we_n_out) |-> (!we_n_out && !cs_n_out) [*3] ##1 we_n_out)
    else $error("write pulse not three cycles");
  chk_write_data: assert property (!we_n_out |-> !data_oe_n_out && $stable(data_out) && oe_n_out)
    else $error("write data not held during the write");
  chk_bus_turn: assert property ($rose(oe_n_out) |-> data_oe_n_out [*2])
    else $error("bus driven before the device released it");
  chk_no_contention: assert property (!oe_n_out |-> data_oe_n_out)
    else $error("bus driven while the device drives it");
  chk_read_access: assert property ($fell(oe_n_out) |-> (!cs_n_out && !oe_n_out) [*4] ##1 resp_valid_out)
    else $error("read strobe not four cycles");
  chk_cmp_driven: assert property ((!cs_n_out && we_n_out && oe_n_out) |-> !data_oe_n_out)
    else $error("data floating during compare");
  chk_resp_latency: assert property (accept |-> ##[5:19] resp_valid_out)
    else $error("response missing after a command");

  cov_read:  cover property (resp_valid_out && resp_out.op == TSM_OP_READ);
  cov_write: cover property (resp_valid_out && resp_out.op == TSM_OP_WRITE);
  cov_hit:   cover property (resp_valid_out && resp_out.op == TSM_OP_CMP && resp_out.hit);
  cov_miss:  cover property (resp_valid_out && resp_out.op == TSM_OP_CMP && !resp_out.hit);
  cov_clear: cover property (resp_valid_out && resp_out.op == TSM_OP_CLEAR);

endmodule
`default_nettype wire

// [design/tsm_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module tsm_timer
  import tsm_pkg::*;
#(
  parameter int W = TSM_TMR_W
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  // Load and status
  input  wire logic         load_in,
  input  wire logic [W-1:0] load_val_in,
  output logic              done_out
);

  logic [W-1:0] count;
  logic [W-1:0] next_count;

  if (W < 2) begin : g_chk
    $error("tsm_timer width too small");
  end

  always_comb begin
    next_count = count;
    if (load_in) begin
      next_count = load_val_in;
    end else if (count != '0) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign done_out = (count == '0);

endmodule
`default_nettype wire

// [testbench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import tsm_pkg::*;
;
  typedef struct packed {
    tsm_op_t    op;
    logic [7:0] rd;
    logic       hit;
    logic [7:0] lat;
    int         tk;
  } tsm_exp_t;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        cmd_valid = 1'b0;
  tsm_cmd_t    cmd = '0;
  tsm_resp_t   resp;
  logic        rdy, rv, doe_n, cs_n, we_n, oe_n, clr_n, match, drv;
  logic        cs_q = 1'b1, we_q = 1'b1, clr_q = 1'b1;
  logic [12:0] addr, a_q = 13'h0000, a;
  logic [7:0]  dout, q, bus, d, d_q = 8'h00, last_bus = 8'h00;
  logic [7:0]  shadow [TSM_WORDS];
  logic [12:0] pool [4];
  tsm_op_t     op;
  tsm_exp_t    expq [$];
  int          mismatches = 0, check_count = 0, cyc = 0, seed = 32'h8df3;
  int          lo = 0, wl = 0, rec = 100, last_clr = -1000;

  always #2.5 clk_in = ~clk_in;
  // Undriven pins show the inverse of their last level
  assign bus = !doe_n ? dout : drv ? q : ~last_bus;
  always @(posedge clk_in) last_bus <= bus;

  tsm_tag_ctrl i_tsm_tag_ctrl (
    .clk_in(clk_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid), .cmd_in(cmd), .cmd_ready_out(rdy),
    .resp_valid_out(rv), .resp_out(resp), .addr_out(addr), .data_out(dout), .data_oe_n_out(doe_n),
    .data_in(bus), .cs_n_out(cs_n), .we_n_out(we_n), .oe_n_out(oe_n), .clear_n_out(clr_n),
    .match_in(match));
  tsm_dev i_tsm_dev (
    .clk_in(clk_in), .a_in(addr), .d_in(bus), .cs_n_in(cs_n), .we_n_in(we_n), .oe_n_in(oe_n),
    .clr_n_in(clr_n), .drv_out(drv), .q_out(q), .match_out(match));

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic end_test(input string nm);
    $display("test %s done", nm);
  endtask

  task automatic send(input tsm_op_t o, input logic [12:0] ad, input logic [7:0] dt);
    tsm_exp_t e;
    e = '{o, 8'h00, 1'b0, 8'h06, 0};
    case (o)
      TSM_OP_READ: e.rd = shadow[ad];
      TSM_OP_WRITE: begin
        e.lat = 8'h05;
        shadow[ad] = dt;
      end
      TSM_OP_CMP: e.hit = (shadow[ad] == dt);
      default: begin
        e.lat = 8'h13;
        foreach (shadow[i])
          shadow[i] = 8'h00;
      end
    endcase
    @(posedge clk_in);
    cmd_valid <= 1'b1;
    cmd <= '{o, ad, dt};
    for (int n = 0; n < 300; n++) begin
      @(posedge clk_in);
      if (rdy === 1'b1) break;
    end
    e.tk = cyc;
    expq.push_back(e);
    cmd_valid <= 1'b0;
    if (o == TSM_OP_CLEAR) begin
      check("clear_spacing", 16'h0001, 16'(cyc - last_clr >= TSM_GAP_INT));
      last_clr = cyc;
    end
  endtask

  always @(posedge clk_in) begin
    tsm_exp_t e;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      finish_test();
    end
    if (!rst_in) begin
      if (rv === 1'b1) begin
        e = expq.pop_front();
        check("resp_op", 16'(e.op), 16'(resp.op));
        check("resp_rdata", 16'(e.rd), 16'(resp.rdata));
        check("resp_hit", 16'(e.hit), 16'(resp.hit));
        check("resp_latency", 16'(e.lat), 16'(cyc - e.tk));
      end
      check("bus_fight", 16'h0000, 16'(!doe_n && drv));
      if (addr !== a_q) check("addr_strobes", 16'h000f, 16'({cs_n, we_n, cs_q, we_q}));
      if (!cs_n && oe_n) check("cmp_data_driven", 16'h0000, 16'(doe_n));
      if (!clr_n) check("we_in_clear", 16'h0001, 16'(we_n));
      if (!we_n) check("we_recovery", 16'h0001, 16'(rec >= TSM_RSRC_INT));
      if (clr_n && !clr_q) check("clear_width", 16'h0001, 16'(lo >= TSM_CLR_INT));
      if (!we_n && !we_q) check("wr_data_hold", 16'(d_q), 16'(dout));
      if (we_n && !we_q) check("wr_width", 16'h0001, 16'(wl >= TSM_WP_INT));
    end
    a_q <= addr;
    d_q <= dout;
    cs_q <= cs_n;
    we_q <= we_n;
    clr_q <= clr_n;
    lo <= clr_n ? 0 : lo + 1;
    wl <= we_n ? 0 : wl + 1;
    rec <= !clr_n ? 0 : (rec < 100 ? rec + 1 : rec);
  end

  initial begin
    for (int i = 0; i < 4; i++)
      pool[i] = 13'($random(seed));
    pool[0] = 13'h0000;
    pool[1] = 13'h1fff;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    check("idle_strobes", 16'h000f, 16'({cs_n, we_n, oe_n, clr_n}));
    check("idle_match", 16'h0001, 16'(match));
    end_test("reset");
    send(TSM_OP_CLEAR, 13'h0000, 8'h00);
    for (int i = 0; i < 2; i++) begin
      send(TSM_OP_READ, pool[i], 8'h00);
      send(TSM_OP_WRITE, pool[i], 8'h3c + 8'(i));
      send(TSM_OP_READ, pool[i], 8'h00);
    end
    end_test("directed");
    for (int b = 0; b < 9; b++)
      send(TSM_OP_CMP, 13'h1fff, 8'h3d ^ 8'(b < 8 ? 1 << b : 0));
    end_test("bits");
    for (int n = 0; n < 60; n++) begin
      a = pool[$unsigned($random(seed)) % 4];
      op = tsm_op_t'(2'($unsigned($random(seed)) % 3));
      d = ($random(seed) & 1) ? shadow[a] : 8'($random(seed));
      send(op, a, d);
    end
    end_test("random");
    send(TSM_OP_CLEAR, 13'h0001, 8'h00);
    send(TSM_OP_CLEAR, 13'h0002, 8'h00);
    send(TSM_OP_READ, pool[1], 8'h00);
    for (int n = 0; n < 50 && expq.size() != 0; n++)
      @(posedge clk_in);
    check("resp_count", 16'h0000, 16'(expq.size()));
    end_test("clear");
    finish_test();
  end
endmodule
`default_nettype wire

// [testbench/tsm_dev.sv]
`timescale 1ns/1ps
`default_nettype none
module tsm_dev
  import tsm_pkg::*;
(
  // Clock
  input  wire logic                  clk_in,
  // Device pins
  input  wire logic [TSM_ADDR_W-1:0] a_in,
  input  wire logic [TSM_DATA_W-1:0] d_in,
  input  wire logic                  cs_n_in,
  input  wire logic                  we_n_in,
  input  wire logic                  oe_n_in,
  input  wire logic                  clr_n_in,
  // Device outputs
  output logic                       drv_out,
  output logic [TSM_DATA_W-1:0]      q_out,
  output logic                       match_out
);
  logic [TSM_DATA_W-1:0] mem [TSM_WORDS];
  logic                  cmp;
  assign cmp       = clr_n_in && !cs_n_in && we_n_in && oe_n_in;
  // Drives only in read mode, so writes keep the pins floating
  assign drv_out   = clr_n_in && !cs_n_in && we_n_in && !oe_n_in;
  assign q_out     = mem[a_in];
  assign match_out = cmp ? (mem[a_in] == d_in) : 1'b1;
  always @(posedge clk_in) begin
    if (!clr_n_in) begin
      foreach (mem[i])
        mem[i] <= 8'h00;
    end else if (!we_n_in && !cs_n_in) begin
      mem[a_in] <= d_in;
    end
  end
endmodule
`default_nettype wire
